/* src/tgen_pkg.sv */
package tgen_pkg;
  localparam int prescale_stages = 2;
  localparam int divider_stages = 21;
  localparam int stage7_index = 6;
  localparam int states_per_cycle = 4;
  localparam int max_instr_cycles = 10;
  localparam logic [1:0] state_reset = 2'h0;
  localparam logic [1:0] state_last = 2'h3;
  localparam logic [3:0] instr_len_reset = 4'h1;
  localparam logic [3:0] instr_len_max = 4'ha;
  typedef enum logic [2:0] {
    high_speed_single_mode,
    high_speed_dual_mode,
    low_speed_both_osc_mode,
    low_speed_hf_off_mode,
    low_speed_sleep_mode,
    stop_mode
  } op_mode_type;
endpackage

/* src/ripple_divider.sv */
`timescale 1ns/10ps
// binary divider chain; each stage toggles when all lower stages and
// the input enable are high; tick flags the cycle a stage goes high
module ripple_divider #(
  parameter int stages = 2
) (
  // clock and clear
  input wire logic mclk,
  input wire logic clear,
  // counting
  input wire logic count_en,
  output logic [stages-1:0] value,
  output logic [stages-1:0] tick
);
  logic [stages-1:0] value_r;
  logic [stages-1:0] carry;

  // carry chain per stage
  genvar g;
  generate
    for (g = 0; g < stages; g++)
    begin : gen_carry
      if (g == 0)
      begin : gen_first
        assign carry[g] = count_en;
      end
      else
      begin : gen_rest
        assign carry[g] = carry[g-1] & value_r[g-1];
      end
    end
  endgenerate

  assign value = value_r;
  assign tick = carry & ~value_r;

  // stage registers
  always_ff @(posedge mclk)
  begin
    if (clear)
      value_r <= '0;
    else
      value_r <= value_r ^ carry;
  end
endmodule

/* src/timing_generator_divider.sv */
`timescale 1ns/10ps
// ************************************************************
// timing generator: prescaler, divider, main clock, states
// ************************************************************
module timing_generator_divider (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // basic clock enables from oscillator domain (pins)
  input wire logic high_freq_clock,
  input wire logic low_freq_clock,
  // mode and select bits from the mode controller
  input wire tgen_pkg::op_mode_type op_mode,
  input wire logic system_clock_select,
  input wire logic seventh_stage_source_select,
  input wire logic stop_active,
  input wire logic warmup_active,
  input wire logic stop_from_high_speed,
  // instruction length of current instruction (1..10)
  input wire logic [3:0] instr_cycles,
  // outputs
  output logic main_clock_en,
  output logic [1:0] machine_state,
  output logic cycle_start,
  output logic instr_done,
  output logic [tgen_pkg::divider_stages-1:0] divider_taps,
  output logic [tgen_pkg::divider_stages-1:0] divider_pulse_output,
  output logic low_speed_active
);
  // ************************************************************
  // input synchronisers and edge detect
  // ************************************************************
  logic [1:0] hf_sync_r;
  logic [1:0] lf_sync_r;
  logic hf_prev_r;
  logic lf_prev_r;
  logic stop_prev_r;
  logic hf_tick;
  logic lf_tick;

  // two flops each, then edge registers read only stage two
  always_ff @(posedge mclk)
  begin
    hf_sync_r <= {hf_sync_r[0], high_freq_clock};
    lf_sync_r <= {lf_sync_r[0], low_freq_clock};
    hf_prev_r <= hf_sync_r[1];
    lf_prev_r <= lf_sync_r[1];
  end

  assign hf_tick = hf_sync_r[1] & ~hf_prev_r;
  assign lf_tick = lf_sync_r[1] & ~lf_prev_r;

  // ************************************************************
  // mode decode and stage seven select
  // ************************************************************
  // select bit one in dual mode also moves the main clock to low speed
  wire low_mode = (op_mode == tgen_pkg::low_speed_both_osc_mode) ||
                  (op_mode == tgen_pkg::low_speed_hf_off_mode) ||
                  (op_mode == tgen_pkg::low_speed_sleep_mode) ||
                  ((op_mode == tgen_pkg::high_speed_dual_mode) &&
                   system_clock_select);
  wire hf_stopped = (op_mode == tgen_pkg::low_speed_hf_off_mode) ||
                    (op_mode == tgen_pkg::low_speed_sleep_mode) ||
                    (op_mode == tgen_pkg::stop_mode);
  wire stop_edge = stop_active ^ stop_prev_r;
  wire chain_clear = reset | stop_edge;
  wire pre_en = hf_tick & ~hf_stopped & ~stop_active;
  logic [tgen_pkg::prescale_stages-1:0] pre_val;
  logic [tgen_pkg::divider_stages-1:0] div_val;
  logic [tgen_pkg::divider_stages-1:0] div_tick;
  logic low_div_en;
  logic [tgen_pkg::stage7_index-1:0] low_val;
  logic [tgen_pkg::stage7_index-1:0] low_tick;
  logic [tgen_pkg::divider_stages-1:tgen_pkg::stage7_index] up_val;
  logic [tgen_pkg::divider_stages-1:tgen_pkg::stage7_index] up_tick;
  wire warm_hs = warmup_active & stop_from_high_speed;
  wire stage6_carry = low_div_en & (&low_val);
  // stage seven input select
  wire stage7_en = stop_active ? 1'b0 :
                   low_mode ? lf_tick :
                   warm_hs ? stage6_carry :
                   seventh_stage_source_select ? lf_tick :
                   stage6_carry;
  // prescaler carry out: a tick while both prescaler stages are high
  assign low_div_en = pre_en & (&pre_val);

  // ************************************************************
  // prescaler and divider chains
  // ************************************************************
  ripple_divider #(.stages(tgen_pkg::prescale_stages)) u_pre (
    .mclk(mclk),
    .clear(chain_clear),
    .count_en(pre_en),
    .value(pre_val),
    .tick()
  );

  ripple_divider #(.stages(tgen_pkg::stage7_index)) u_low (
    .mclk(mclk),
    .clear(chain_clear),
    .count_en(low_div_en),
    .value(low_val),
    .tick(low_tick)
  );

  ripple_divider #(.stages(tgen_pkg::divider_stages -
                           tgen_pkg::stage7_index)) u_up (
    .mclk(mclk),
    .clear(chain_clear),
    .count_en(stage7_en),
    .value(up_val),
    .tick(up_tick)
  );

  assign div_val = {up_val, low_val};
  assign div_tick = {up_tick, low_tick};

  // ************************************************************
  // main system clock and machine states
  // ************************************************************
  // high speed uses basic hf clock, low speed the low clock
  wire main_src = stop_active ? 1'b0 :
                  low_mode ? lf_tick : hf_tick;
  logic [1:0] state_r;
  logic [1:0] state_nxt;
  logic [3:0] mcyc_r;
  logic [3:0] mcyc_nxt;
  wire last_state = main_src && (state_r == tgen_pkg::state_last);
  wire [3:0] instr_len = (instr_cycles == 4'h0) ? tgen_pkg::instr_len_reset :
                         (instr_cycles > tgen_pkg::instr_len_max) ?
                         tgen_pkg::instr_len_max : instr_cycles;
  wire instr_end = last_state && (mcyc_r + 4'h1 >= instr_len);
  assign state_nxt = main_src ? state_r + 2'h1 : state_r;
  assign mcyc_nxt = !last_state ? mcyc_r :
                    instr_end ? 4'h0 : mcyc_r + 4'h1;

  // state counters
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state_r <= tgen_pkg::state_reset;
      mcyc_r <= 4'h0;
    end
    else
    begin
      state_r <= state_nxt;
      mcyc_r <= mcyc_nxt;
    end
  end

  // ************************************************************
  // registered outputs
  // ************************************************************
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      stop_prev_r <= 1'b0;
      main_clock_en <= 1'b0;
      machine_state <= tgen_pkg::state_reset;
      cycle_start <= 1'b0;
      instr_done <= 1'b0;
      divider_taps <= '0;
      divider_pulse_output <= '0;
      low_speed_active <= 1'b0;
    end
    else
    begin
      stop_prev_r <= stop_active;
      main_clock_en <= main_src;
      machine_state <= state_nxt;
      cycle_start <= last_state;
      instr_done <= instr_end;
      divider_taps <= div_val;
      divider_pulse_output <= div_tick;
      low_speed_active <= low_mode;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  property p_clear_on_stop;
    @(posedge mclk) disable iff (reset)
    stop_edge |=> (div_val == '0) && (pre_val == '0);
  endproperty
  a_clear_on_stop: assert property (p_clear_on_stop)
    else $error("chain not cleared on stop change");

  property p_low_feeds_seven;
    @(posedge mclk) disable iff (reset)
    (low_mode && !stop_active) |-> (stage7_en == lf_tick);
  endproperty
  a_low_feeds_seven: assert property (p_low_feeds_seven)
    else $error("low mode stage seven not low clock");

  property p_warm_six;
    @(posedge mclk) disable iff (reset)
    (warm_hs && !low_mode && !stop_active) |-> stage7_en == stage6_carry;
  endproperty
  a_warm_six: assert property (p_warm_six)
    else $error("warm-up stage seven not stage six");

  property p_hs_select;
    @(posedge mclk) disable iff (reset)
    (!low_mode && !warm_hs && !stop_active &&
     seventh_stage_source_select) |-> stage7_en == lf_tick;
  endproperty
  a_hs_select: assert property (p_hs_select)
    else $error("select one did not pick low clock");

  property p_hf_off_silent;
    @(posedge mclk) disable iff (reset)
    (hf_stopped && !chain_clear) |=> $stable(low_val);
  endproperty
  a_hf_off_silent: assert property (p_hf_off_silent)
    else $error("low stages moved with hf stopped");

  property p_state_wrap;
    @(posedge mclk) disable iff (reset)
    last_state |=> (machine_state == 2'h0) && cycle_start;
  endproperty
  a_state_wrap: assert property (p_state_wrap)
    else $error("state did not wrap to zero");

  property p_state_hold;
    @(posedge mclk) disable iff (reset)
    !main_src |=> state_r == $past(state_r);
  endproperty
  a_state_hold: assert property (p_state_hold)
    else $error("state advanced without main clock");

  property p_instr_bound;
    @(posedge mclk) disable iff (reset)
    mcyc_r < tgen_pkg::instr_len_max;
  endproperty
  a_instr_bound: assert property (p_instr_bound)
    else $error("instruction exceeded ten cycles");

  property p_main_follow;
    @(posedge mclk) disable iff (reset)
    (!low_mode && !stop_active && hf_tick) |=> main_clock_en;
  endproperty
  a_main_follow: assert property (p_main_follow)
    else $error("main clock missed hf tick");
endmodule

/* bench/timing_generator_divider_bench.sv */
`timescale 1ns/10ps
module timing_generator_divider_bench;
  // clock, reset and stimulus
  logic mclk;
  logic reset;
  logic high_freq_clock;
  logic low_freq_clock;
  tgen_pkg::op_mode_type op_mode;
  logic system_clock_select;
  logic seventh_stage_source_select;
  logic stop_active;
  logic warmup_active;
  logic stop_from_high_speed;
  logic [3:0] instr_cycles;
  // observed outputs
  logic main_clock_en;
  logic [1:0] machine_state;
  logic cycle_start;
  logic instr_done;
  logic [tgen_pkg::divider_stages-1:0] divider_taps;
  logic [tgen_pkg::divider_stages-1:0] divider_pulse_output;
  logic low_speed_active;
  int err_total;
  int checked;
  int n_main;
  int n_cyc;
  int n_done;
  int n_p0;

  timing_generator_divider u_timing_generator_divider (
    .mclk(mclk), .reset(reset), .high_freq_clock(high_freq_clock),
    .low_freq_clock(low_freq_clock), .op_mode(op_mode),
    .system_clock_select(system_clock_select),
    .seventh_stage_source_select(seventh_stage_source_select),
    .stop_active(stop_active), .warmup_active(warmup_active),
    .stop_from_high_speed(stop_from_high_speed),
    .instr_cycles(instr_cycles), .main_clock_en(main_clock_en),
    .machine_state(machine_state), .cycle_start(cycle_start),
    .instr_done(instr_done), .divider_taps(divider_taps),
    .divider_pulse_output(divider_pulse_output),
    .low_speed_active(low_speed_active)
  );

  // 250 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // pulse counters
  always @(posedge mclk)
  begin
    n_main += (main_clock_en === 1'b1);
    n_cyc += (cycle_start === 1'b1);
    n_done += (instr_done === 1'b1);
    n_p0 += (divider_pulse_output[0] === 1'b1);
  end

  task automatic chk(input string what, input logic [20:0] exp,
                     input logic [20:0] got);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic clr();
    @(negedge mclk);
    n_main = 0;
    n_cyc = 0;
    n_done = 0;
    n_p0 = 0;
  endtask

  // basic clock edges kept well apart for the synchronisers
  task automatic ticks(input bit lf, input int n);
    repeat (n)
    begin
      @(posedge mclk);
      if (lf) low_freq_clock <= 1'b1; else high_freq_clock <= 1'b1;
      repeat (4) @(posedge mclk);
      if (lf) low_freq_clock <= 1'b0; else high_freq_clock <= 1'b0;
      repeat (3) @(posedge mclk);
    end
    repeat (8) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic setm(input tgen_pkg::op_mode_type m, input bit sel,
                      input bit warm, input bit slow);
    @(posedge mclk);
    op_mode <= m;
    seventh_stage_source_select <= sel;
    warmup_active <= warm;
    stop_from_high_speed <= warm;
    system_clock_select <= slow;
  endtask

  // stop entry then release, each clearing the chain
  task automatic clear_chain();
    @(posedge mclk);
    stop_active <= 1'b1;
    repeat (4) @(posedge mclk);
    stop_active <= 1'b0;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic test_machine_cycle();
    setm(tgen_pkg::high_speed_single_mode, 1'b0, 1'b0, 1'b0);
    instr_cycles <= 4'h2;
    clr();
    ticks(1'b0, 16);
    chk("main_clock_en count", 21'h10, n_main[20:0]);
    chk("cycle_start count", 21'h4, n_cyc[20:0]);
    chk("machine_state", 21'h0, {19'h0, machine_state});
    chk("instr_done count", 21'h2, n_done[20:0]);
    chk("divider_taps", 21'h4, divider_taps);
    chk("stage one pulses", 21'h2, n_p0[20:0]);
    chk("low_speed_active", 21'h0, {20'h0, low_speed_active});
    $display("test_machine_cycle done");
  endtask

  task automatic test_stop_clear();
    setm(tgen_pkg::stop_mode, 1'b0, 1'b0, 1'b0);
    stop_active <= 1'b1;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    chk("taps on stop entry", 21'h0, divider_taps);
    clr();
    ticks(1'b0, 8);
    chk("taps during stop", 21'h0, divider_taps);
    chk("main during stop", 21'h0, n_main[20:0]);
    setm(tgen_pkg::high_speed_single_mode, 1'b0, 1'b0, 1'b0);
    stop_active <= 1'b0;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    chk("taps on stop release", 21'h0, divider_taps);
    $display("test_stop_clear done");
  endtask

  task automatic test_low_speed();
    tgen_pkg::op_mode_type m;
    for (int i = 0; i < 3; i++)
    begin
      m = (i == 0) ? tgen_pkg::low_speed_hf_off_mode :
          (i == 1) ? tgen_pkg::low_speed_sleep_mode :
          tgen_pkg::low_speed_both_osc_mode;
      setm(m, 1'b0, 1'b0, 1'b1);
      clear_chain();
      clr();
      ticks(1'b0, 8);
      chk("hf taps low", (i == 2) ? 21'h2 : 21'h0, divider_taps);
      ticks(1'b1, 3);
      chk("lf taps low", (i == 2) ? 21'hc2 : 21'hc0, divider_taps);
      chk("low_speed_active", 21'h1, {20'h0, low_speed_active});
      if (i == 0)
        chk("main from lf", 21'h3, n_main[20:0]);
    end
    $display("test_low_speed done");
  endtask

  task automatic test_dual_select();
    setm(tgen_pkg::high_speed_dual_mode, 1'b1, 1'b0, 1'b0);
    clear_chain();
    ticks(1'b1, 2);
    chk("lf into stage seven", 21'h80, divider_taps);
    setm(tgen_pkg::high_speed_dual_mode, 1'b0, 1'b0, 1'b0);
    clear_chain();
    ticks(1'b1, 2);
    chk("lf ignored", 21'h0, divider_taps);
    ticks(1'b0, 256);
    chk("stage six carry", 21'h40, divider_taps);
    chk("low_speed_active", 21'h0, {20'h0, low_speed_active});
    setm(tgen_pkg::high_speed_dual_mode, 1'b0, 1'b0, 1'b1);
    clr();
    ticks(1'b1, 2);
    chk("main from lf on select", 21'h2, n_main[20:0]);
    chk("slow select active", 21'h1, {20'h0, low_speed_active});
    $display("test_dual_select done");
  endtask

  task automatic test_warmup();
    setm(tgen_pkg::high_speed_dual_mode, 1'b1, 1'b1, 1'b0);
    clear_chain();
    ticks(1'b1, 4);
    chk("lf ignored in warmup", 21'h0, divider_taps);
    ticks(1'b0, 256);
    chk("stage six in warmup", 21'h40, divider_taps);
    setm(tgen_pkg::high_speed_dual_mode, 1'b0, 1'b0, 1'b0);
    $display("test_warmup done");
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    err_total = 0;
    checked = 0;
    n_main = 0;
    n_cyc = 0;
    n_done = 0;
    n_p0 = 0;
    reset = 1'b1;
    high_freq_clock = 1'b0;
    low_freq_clock = 1'b0;
    op_mode = tgen_pkg::high_speed_single_mode;
    system_clock_select = 1'b0;
    seventh_stage_source_select = 1'b0;
    stop_active = 1'b0;
    warmup_active = 1'b0;
    stop_from_high_speed = 1'b0;
    instr_cycles = 4'h1;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    @(negedge mclk);
    chk("taps after reset", 21'h0, divider_taps);
    chk("state after reset", 21'h0, {19'h0, machine_state});
    test_machine_cycle();
    test_stop_clear();
    test_low_speed();
    test_dual_select();
    test_warmup();
    give_verdict();
  end
endmodule
